/* rtl/icm_monitor.sv */
`timescale 1ns/1ps
module icm_monitor (
  // clock and reset
  input  wire logic       CLK,
  input  wire logic       NRST,
  // register port
  input  wire logic [7:0] ADDR,
  input  wire logic [7:0] WDATA,
  input  wire logic       WR,
  input  wire logic       RD,
  output logic      [7:0] RDATA,
  // clock line pin
  input  wire logic       SCL_IN,
  output logic            SCL_OUT,
  output logic            SCL_OE,
  // data line pin
  input  wire logic       SDA_IN,
  output logic            SDA_OUT,
  output logic            SDA_OE,
  // interrupt
  output logic            IRQ
);
  typedef struct packed {
    logic [7:0] ictl;
    logic [7:0] pir;
    logic [7:0] pie;
    logic [7:0] buffer;
    logic [7:0] con;
    logic [7:0] stat;
    logic [7:0] dir;
    logic [7:0] latch;
    logic [7:0] addr;
    logic [7:0] rdata;
    logic       scl_oe;
    logic       sda_oe;
    logic       irq;
  } icm_state_t;

  icm_state_t st;
  icm_state_t next_st;

  logic       port_on;
  logic       mode_i2c;
  logic       slave_on;
  logic       start_ev;
  logic       stop_ev;
  logic       rx_done;
  logic [7:0] rx_data;
  logic       rx_is_addr;
  logic       rx_hit;
  logic       rx_ack;
  logic [3:0] mode;

  assign mode     = st.con[icm_pkg::MODE_LO +: icm_pkg::MODE_W];
  assign port_on  = st.con[icm_pkg::EN_BIT];
  assign mode_i2c = (mode == icm_pkg::MODE_SLV7) || (mode == icm_pkg::MODE_SLV10)
                 || (mode == icm_pkg::MODE_FWMASTER) || (mode == icm_pkg::MODE_SLV7_SP)
                 || (mode == icm_pkg::MODE_SLV10_SP);
  // slave logic stays idle in firmware-master mode
  assign slave_on = port_on && mode_i2c && (mode != icm_pkg::MODE_FWMASTER);

  icm_cond_detect u_cond (
    .clk        (CLK),
    .nrst       (NRST),
    .clear      (!(port_on && mode_i2c)),
    .scl        (SCL_IN),
    .sda        (SDA_IN),
    .start_seen (start_ev),
    .stop_seen  (stop_ev)
  );

  icm_slave_rx u_rx (
    .clk        (CLK),
    .nrst       (NRST),
    .active     (slave_on),
    .own_addr   (st.addr[7:1]),
    .start_seen (start_ev),
    .stop_seen  (stop_ev),
    .scl        (SCL_IN),
    .sda        (SDA_IN),
    .byte_done  (rx_done),
    .byte_data  (rx_data),
    .is_addr    (rx_is_addr),
    .addr_hit   (rx_hit),
    .ack_drive  (rx_ack)
  );

  always_comb begin
    next_st = st;
    // register writes
    if (WR) begin
      case (ADDR)
        icm_pkg::ADDR_IRQ_CTRL: next_st.ictl = WDATA;
        icm_pkg::ADDR_PIR:    next_st.pir    = WDATA;
        icm_pkg::ADDR_PIE:    next_st.pie    = WDATA;
        icm_pkg::ADDR_BUF:    next_st.buffer = WDATA;
        icm_pkg::ADDR_CON:    next_st.con    = WDATA;
        icm_pkg::ADDR_DIR:    next_st.dir    = WDATA;
        icm_pkg::ADDR_LATCH:  next_st.latch  = WDATA;
        icm_pkg::ADDR_ADD:    next_st.addr   = WDATA;
        icm_pkg::ADDR_STAT: begin
          next_st.stat[icm_pkg::SAMPLE_BIT] = WDATA[icm_pkg::SAMPLE_BIT];
          next_st.stat[icm_pkg::CKE_BIT] = WDATA[icm_pkg::CKE_BIT];
        end
        default: begin
        end
      endcase
    end
    // reading the buffer empties it
    if (RD && ADDR == icm_pkg::ADDR_BUF) begin
      next_st.stat[icm_pkg::FULL_BIT] = 1'b0;
    end
    // received bytes from slave logic
    if (rx_done) begin
      if (st.stat[icm_pkg::FULL_BIT] || st.con[icm_pkg::OV_BIT]) begin
        next_st.con[icm_pkg::OV_BIT] = 1'b1;
      end else begin
        next_st.buffer                 = rx_data;
        next_st.stat[icm_pkg::FULL_BIT] = 1'b1;
        next_st.stat[icm_pkg::DA_BIT]  = !rx_is_addr;
      end
      next_st.pir[icm_pkg::IRQ_BIT] = 1'b1;
    end
    // bus condition flags
    if (start_ev) begin
      next_st.stat[icm_pkg::S_BIT] = 1'b1;
      next_st.stat[icm_pkg::P_BIT] = 1'b0;
      next_st.pir[icm_pkg::IRQ_BIT] = 1'b1;
    end
    if (stop_ev) begin
      next_st.stat[icm_pkg::P_BIT] = 1'b1;
      next_st.stat[icm_pkg::S_BIT] = 1'b0;
      // stop raises the flag, so enabling while busy fires here
      next_st.pir[icm_pkg::IRQ_BIT] = 1'b1;
    end
    if (!port_on) begin
      next_st.stat[icm_pkg::S_BIT] = 1'b0;
      next_st.stat[icm_pkg::P_BIT] = 1'b0;
    end
    // read data, one cycle later
    next_st.rdata = icm_pkg::RST_ZERO;
    if (RD) begin
      case (ADDR)
        icm_pkg::ADDR_IRQ_CTRL: next_st.rdata = st.ictl;
        icm_pkg::ADDR_PIR:    next_st.rdata = st.pir;
        icm_pkg::ADDR_PIE:    next_st.rdata = st.pie;
        icm_pkg::ADDR_BUF:    next_st.rdata = st.buffer;
        icm_pkg::ADDR_CON:    next_st.rdata = st.con;
        icm_pkg::ADDR_DIR:    next_st.rdata = st.dir;
        icm_pkg::ADDR_LATCH:  next_st.rdata = st.latch;
        icm_pkg::ADDR_ADD:    next_st.rdata = st.addr;
        icm_pkg::ADDR_STAT:   next_st.rdata = st.stat;
        default:              next_st.rdata = icm_pkg::RST_ZERO;
      endcase
    end
    // pins: output direction drives low, input floats; slave ack pulls data low
    next_st.scl_oe = !next_st.dir[icm_pkg::SCL_BIT];
    next_st.sda_oe = !next_st.dir[icm_pkg::SDA_BIT] || (rx_ack && slave_on);
    next_st.irq    = next_st.ictl[icm_pkg::GLB_EN_BIT] && next_st.ictl[icm_pkg::PER_EN_BIT]
                  && next_st.pir[icm_pkg::IRQ_BIT] && next_st.pie[icm_pkg::IRQ_BIT];
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      st <= '{ictl: icm_pkg::RST_ZERO, pir: icm_pkg::RST_ZERO, pie: icm_pkg::RST_ZERO,
              buffer: icm_pkg::RST_ZERO, con: icm_pkg::RST_CON, stat: icm_pkg::RST_STAT,
              dir: icm_pkg::RST_DIR, latch: icm_pkg::RST_ZERO, addr: icm_pkg::RST_ADD,
              rdata: icm_pkg::RST_ZERO, scl_oe: 1'b0, sda_oe: 1'b0, irq: 1'b0};
    end else begin
      st <= next_st;
    end
  end

  // driven level is always low regardless of the latch
  assign SCL_OUT = 1'b0;
  assign SDA_OUT = 1'b0;
  assign SCL_OE  = st.scl_oe;
  assign SDA_OE  = st.sda_oe;
  assign RDATA   = st.rdata;
  assign IRQ     = st.irq;
endmodule : icm_monitor

/* rtl/icm_pkg.sv */
package icm_pkg;
  // register addresses
  localparam logic [7:0] ADDR_IRQ_CTRL = 8'h0B;
  localparam logic [7:0] ADDR_PIR    = 8'h0C;
  localparam logic [7:0] ADDR_BUF    = 8'h13;
  localparam logic [7:0] ADDR_CON    = 8'h14;
  localparam logic [7:0] ADDR_DIR    = 8'h87;
  localparam logic [7:0] ADDR_PIE    = 8'h8C;
  localparam logic [7:0] ADDR_ADD    = 8'h93;
  localparam logic [7:0] ADDR_STAT   = 8'h94;
  localparam logic [7:0] ADDR_LATCH  = 8'h07;
  // reset values
  localparam logic [7:0] RST_CON  = 8'h00;
  localparam logic [7:0] RST_STAT = 8'h00;
  localparam logic [7:0] RST_DIR  = 8'hFF;
  localparam logic [7:0] RST_ADD  = 8'h00;
  localparam logic [7:0] RST_ZERO = 8'h00;
  // field positions
  localparam int GLB_EN_BIT   = 7;
  localparam int PER_EN_BIT   = 6;
  localparam int IRQ_BIT      = 3;
  localparam int COLLIDE_BIT  = 7;
  localparam int OV_BIT       = 6;
  localparam int EN_BIT       = 5;
  localparam int REL_CLK_BIT  = 4;
  localparam int SAMPLE_BIT   = 7;
  localparam int CKE_BIT  = 6;
  localparam int DA_BIT   = 5;
  localparam int P_BIT    = 4;
  localparam int S_BIT    = 3;
  localparam int RW_BIT   = 2;
  localparam int ADDR_UPD_BIT = 1;
  localparam int FULL_BIT     = 0;
  localparam int SDA_BIT  = 4;
  localparam int SCL_BIT  = 3;
  // port mode field
  localparam logic [3:0] MODE_SLV7     = 4'h6;
  localparam logic [3:0] MODE_SLV10    = 4'h7;
  localparam logic [3:0] MODE_FWMASTER = 4'hB;
  localparam logic [3:0] MODE_SLV7_SP  = 4'hE;
  localparam logic [3:0] MODE_SLV10_SP = 4'hF;
  localparam int          MODE_LO  = 0;
  localparam int          MODE_W   = 4;
endpackage : icm_pkg

/* rtl/icm_cond_detect.sv */
`timescale 1ns/1ps
module icm_cond_detect (
  // clock and reset
  input  wire logic clk,
  input  wire logic nrst,
  // control
  input  wire logic clear,
  // bus lines
  input  wire logic scl,
  input  wire logic sda,
  // events
  output logic      start_seen,
  output logic      stop_seen
);
  typedef struct packed {
    logic scl_q;
    logic sda_q;
    logic start_seen;
    logic stop_seen;
  } icm_cd_state_t;

  icm_cd_state_t st;
  icm_cd_state_t next_st;

  always_comb begin
    next_st            = st;
    next_st.scl_q      = scl;
    next_st.sda_q      = sda;
    // start: data falls while clock high; stop: data rises while clock high
    next_st.start_seen = !clear && st.scl_q && scl && st.sda_q && !sda;
    next_st.stop_seen  = !clear && st.scl_q && scl && !st.sda_q && sda;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st <= '{scl_q: 1'b1, sda_q: 1'b1, start_seen: 1'b0, stop_seen: 1'b0};
    end else begin
      st <= next_st;
    end
  end

  assign start_seen = st.start_seen;
  assign stop_seen  = st.stop_seen;
endmodule : icm_cond_detect

/* rtl/icm_slave_rx.sv */
`timescale 1ns/1ps
module icm_slave_rx (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       nrst,
  // control
  input  wire logic       active,
  input  wire logic [6:0] own_addr,
  input  wire logic       start_seen,
  input  wire logic       stop_seen,
  // bus lines
  input  wire logic       scl,
  input  wire logic       sda,
  // results
  output logic            byte_done,
  output logic [7:0]      byte_data,
  output logic            is_addr,
  output logic            addr_hit,
  output logic            ack_drive
);
  typedef enum logic [1:0] {IDLE, SHIFT, ACK, SKIP} icm_rx_phase_t;
  typedef struct packed {
    icm_rx_phase_t phase;
    logic          scl_q;
    logic [3:0]    cnt;
    logic [7:0]    sh;
    logic          first;
    logic          hit;
    logic          ack;
    logic          done;
  } icm_rx_state_t;

  icm_rx_state_t st;
  icm_rx_state_t next_st;
  logic          rise;
  logic          fall;

  always_comb begin
    next_st       = st;
    next_st.scl_q = scl;
    next_st.done  = 1'b0;
    rise          = scl && !st.scl_q;
    fall          = !scl && st.scl_q;
    if (!active || stop_seen) begin
      next_st.phase = IDLE;
      next_st.ack   = 1'b0;
    end else if (start_seen) begin
      // a start restarts reception only while active; the monitor holds active low in firmware-master mode
      next_st.phase = SHIFT;
      next_st.cnt   = 4'h0;
      next_st.first = 1'b1;
      next_st.hit   = 1'b0;
      next_st.ack   = 1'b0;
    end else begin
      case (st.phase)
        IDLE: begin
          next_st.ack = 1'b0;
        end
        SHIFT: begin
          if (rise) begin
            next_st.sh  = {st.sh[6:0], sda};
            next_st.cnt = st.cnt + 4'h1;
          end
          if (fall && st.cnt == 4'h8) begin
            next_st.done = st.first ? (st.sh[7:1] == own_addr) : st.hit;
            if (st.first) begin
              next_st.hit = (st.sh[7:1] == own_addr);
            end
            // acknowledge an address that matches, and each data byte after a match
            next_st.ack   = st.first ? (st.sh[7:1] == own_addr) : st.hit;
            next_st.phase = ACK;
          end
        end
        ACK: begin
          if (fall) begin
            next_st.ack   = 1'b0;
            next_st.first = 1'b0;
            next_st.cnt   = 4'h0;
            next_st.phase = st.hit ? SHIFT : SKIP;
          end
        end
        SKIP: begin
          next_st.ack = 1'b0;
        end
        default: begin
          next_st.phase = IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st <= '{phase: IDLE, scl_q: 1'b1, cnt: 4'h0, sh: 8'h00, first: 1'b0, hit: 1'b0, ack: 1'b0, done: 1'b0};
    end else begin
      st <= next_st;
    end
  end

  assign byte_done = st.done;
  assign byte_data = st.sh;
  assign is_addr   = st.first;
  assign addr_hit  = st.hit;
  assign ack_drive = st.ack;
endmodule : icm_slave_rx

/* dv/icm_monitor_properties.sv */
`timescale 1ns/1ps
module icm_monitor_properties (
  // clock and reset
  input wire logic       CLK,
  input wire logic       NRST,
  // register port
  input wire logic [7:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic       WR,
  input wire logic       RD,
  input wire logic [7:0] RDATA,
  // pins and interrupt
  input wire logic       SCL_IN,
  input wire logic       SCL_OUT,
  input wire logic       SCL_OE,
  input wire logic       SDA_IN,
  input wire logic       SDA_OUT,
  input wire logic       SDA_OE,
  input wire logic       IRQ
);
  logic [3:0] quiet;
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!NRST);
  // cycles since the last line change
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) quiet <= 4'h0;
    else if ($changed(SDA_IN) || $changed(SCL_IN)) quiet <= 4'h0;
    else if (quiet != 4'hF) quiet <= quiet + 4'h1;
  end
  a_sda_out_low: assert property (SDA_OUT == 1'b0)
    else $error("sda drive level not low");
  a_scl_out_low: assert property (SCL_OUT == 1'b0)
    else $error("scl drive level not low");
  a_scl_dir_follow: assert property (WR && ADDR == icm_pkg::ADDR_DIR |=>
    SCL_OE == !$past(WDATA[icm_pkg::SCL_BIT])) else $error("scl enable not per direction");
  a_sda_dir_low: assert property (WR && ADDR == icm_pkg::ADDR_DIR && !WDATA[icm_pkg::SDA_BIT] |=> SDA_OE)
    else $error("sda not pulled for output direction");
  a_scl_oe_hold: assert property (!(WR && ADDR == icm_pkg::ADDR_DIR) |=> $stable(SCL_OE))
    else $error("scl enable moved without write");
  a_irq_has_cause: assert property ($rose(IRQ) |-> $past(WR) || $past(WR, 2) || quiet < 4'h8)
    else $error("interrupt rose without event");
  a_irq_flag_clear: assert property (WR && ADDR == icm_pkg::ADDR_PIR && !WDATA[icm_pkg::IRQ_BIT]
    && quiet > 4'h9 |=> !IRQ) else $error("interrupt stayed after flag clear");
  a_irq_global_mask: assert property (WR && ADDR == icm_pkg::ADDR_IRQ_CTRL
    && !WDATA[icm_pkg::GLB_EN_BIT] |=> !IRQ) else $error("interrupt not masked");
  c_irq: cover property ($rose(IRQ));
  c_sda_pull: cover property ($rose(SDA_OE));
  c_stat_read: cover property (RD && ADDR == icm_pkg::ADDR_STAT);
endmodule : icm_monitor_properties
bind icm_monitor icm_monitor_properties u_props (.CLK(CLK), .NRST(NRST), .ADDR(ADDR), .WDATA(WDATA),
  .WR(WR), .RD(RD), .RDATA(RDATA), .SCL_IN(SCL_IN), .SCL_OUT(SCL_OUT), .SCL_OE(SCL_OE),
  .SDA_IN(SDA_IN), .SDA_OUT(SDA_OUT), .SDA_OE(SDA_OE), .IRQ(IRQ));

/* dv/icm_bus_partner.sv */
`timescale 1ns/1ps
module icm_bus_partner (
  // timing and sensed line
  input  wire logic clk,
  input  wire logic sda,
  // open-drain pulls, high pulls low
  output logic      scl_low,
  output logic      sda_low
);
  initial begin
    scl_low = 1'b0;
    sda_low = 1'b0;
  end
  task automatic half();
    repeat (16) @(posedge clk);
  endtask : half
  // data falls with clock high; only called with the bus free
  task automatic start_cond();
    sda_low <= 1'b1;
    half();
    scl_low <= 1'b1;
    half();
  endtask : start_cond
  // data rises with clock high
  task automatic stop_cond();
    sda_low <= 1'b1;
    half();
    scl_low <= 1'b0;
    half();
    sda_low <= 1'b0;
    half();
  endtask : stop_cond
  // msb first, data moves only while clock is low, then the ack clock
  task automatic send_byte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      sda_low <= !b[i];
      half();
      scl_low <= 1'b0;
      half();
      scl_low <= 1'b1;
      half();
    end
    sda_low <= 1'b0;
    half();
    scl_low <= 1'b0;
    half();
    ack = !sda;
    scl_low <= 1'b1;
    half();
  endtask : send_byte
endmodule : icm_bus_partner

/* dv/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
  localparam logic [7:0] CON_FW = {4'h2, icm_pkg::MODE_FWMASTER};
  localparam logic [7:0] CON_SL = {4'h2, icm_pkg::MODE_SLV7};
  logic       CLK;
  logic       NRST;
  logic [7:0] ADDR;
  logic [7:0] WDATA;
  logic       WR;
  logic       RD;
  logic [7:0] RDATA;
  logic       SCL_OUT, SCL_OE, SDA_OUT, SDA_OE, IRQ;
  logic       scl, sda, scl_low, sda_low, ack;
  logic [7:0] got;
  int         miscompares = 0;
  int         tests_run = 0;
  int         cycles = 0;
  // wired-and lines with pull-ups
  assign scl = !(SCL_OE || scl_low);
  assign sda = !(SDA_OE || sda_low);
  icm_monitor u_dut (.CLK(CLK), .NRST(NRST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
    .SCL_IN(scl), .SCL_OUT(SCL_OUT), .SCL_OE(SCL_OE), .SDA_IN(sda), .SDA_OUT(SDA_OUT), .SDA_OE(SDA_OE), .IRQ(IRQ));
  icm_bus_partner u_bus (.clk(CLK), .sda(sda), .scl_low(scl_low), .sda_low(sda_low));
  always #4 CLK = !CLK;
  task automatic summarize();
    $display("tests_run=%0d miscompares=%0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : summarize
  always @(posedge CLK) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      summarize();
    end
  end
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    tests_run++;
    if (g !== e) begin
      miscompares++;
      $display("BAD %0t got %h expected %h", $time, g, e);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge CLK);
    ADDR <= a;
    WDATA <= d;
    WR <= 1'b1;
    @(posedge CLK);
    WR <= 1'b0;
  endtask : wr
  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    @(posedge CLK);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge CLK);
    RD <= 1'b0;
    #1 chk(RDATA, e);
  endtask : rc
  task automatic settle();
    repeat (8) @(posedge CLK);
    #1;
  endtask : settle
  task automatic t_reset();
    rc(icm_pkg::ADDR_STAT, 8'h00);
    wr(icm_pkg::ADDR_STAT, 8'h3F);
    rc(icm_pkg::ADDR_STAT, 8'h00);
    rc(icm_pkg::ADDR_CON, 8'h00);
    rc(icm_pkg::ADDR_DIR, 8'hFF);
    rc(icm_pkg::ADDR_ADD, 8'h00);
    rc(8'h55, 8'h00);
    chk({6'h0, SDA_OE, SCL_OE}, 8'h00);
    chk({6'h0, SDA_OUT, SCL_OUT}, 8'h00);
  endtask : t_reset
  task automatic t_master();
    wr(icm_pkg::ADDR_IRQ_CTRL, 8'hC0);
    wr(icm_pkg::ADDR_PIE, 8'h08);
    wr(icm_pkg::ADDR_CON, CON_FW);
    wr(icm_pkg::ADDR_LATCH, 8'hFF);
    wr(icm_pkg::ADDR_DIR, 8'hEF);
    settle();
    chk({7'h0, SDA_OE}, 8'h01);
    rc(icm_pkg::ADDR_STAT, 8'h08);
    chk({7'h0, IRQ}, 8'h01);
    wr(icm_pkg::ADDR_PIR, 8'h00);
    wr(icm_pkg::ADDR_DIR, 8'hE7);
    settle();
    chk({6'h0, SDA_OE, SCL_OE}, 8'h03);
    wr(icm_pkg::ADDR_DIR, 8'hEF);
    settle();
    wr(icm_pkg::ADDR_DIR, 8'hFF);
    settle();
    rc(icm_pkg::ADDR_STAT, 8'h10);
    chk({6'h0, SDA_OE, SCL_OE}, 8'h00);
  endtask : t_master
  task automatic t_disable();
    wr(icm_pkg::ADDR_CON, {4'h0, icm_pkg::MODE_FWMASTER});
    rc(icm_pkg::ADDR_STAT, 8'h00);
    wr(icm_pkg::ADDR_CON, CON_FW);
  endtask : t_disable
  task automatic t_busy_irq();
    wr(icm_pkg::ADDR_PIE, 8'h00);
    u_bus.start_cond();
    chk({7'h0, sda}, 8'h00);
    wr(icm_pkg::ADDR_DIR, 8'hFF);
    wr(icm_pkg::ADDR_PIR, 8'h00);
    rc(icm_pkg::ADDR_STAT, 8'h08);
    wr(icm_pkg::ADDR_PIE, 8'h08);
    settle();
    chk({7'h0, IRQ}, 8'h00);
    u_bus.stop_cond();
    settle();
    chk({7'h0, IRQ}, 8'h01);
    rc(icm_pkg::ADDR_STAT, 8'h10);
    wr(icm_pkg::ADDR_IRQ_CTRL, 8'h00);
    settle();
    chk({7'h0, IRQ}, 8'h00);
    wr(icm_pkg::ADDR_IRQ_CTRL, 8'hC0);
    wr(icm_pkg::ADDR_PIR, 8'h00);
  endtask : t_busy_irq
  task automatic t_slave(input logic [7:0] con, input logic exp_ack, input logic [7:0] exp_stat,
                         input logic [7:0] exp_buf, input logic [7:0] exp_pir);
    wr(icm_pkg::ADDR_CON, con);
    wr(icm_pkg::ADDR_ADD, 8'hFF);
    u_bus.start_cond();
    wr(icm_pkg::ADDR_PIR, 8'h00);
    u_bus.send_byte(8'hFE, ack);
    chk({7'h0, ack}, {7'h0, exp_ack});
    rc(icm_pkg::ADDR_STAT, exp_stat);
    rc(icm_pkg::ADDR_BUF, exp_buf);
    wr(icm_pkg::ADDR_PIR, 8'h00);
    u_bus.send_byte(8'h5A, ack);
    rc(icm_pkg::ADDR_PIR, exp_pir);
    rc(icm_pkg::ADDR_BUF, 8'h5A);
    u_bus.stop_cond();
    wr(icm_pkg::ADDR_PIR, 8'h00);
  endtask : t_slave
  initial begin
    CLK = 1'b0;
    NRST = 1'b0;
    ADDR = 8'h00;
    WDATA = 8'h00;
    WR = 1'b0;
    RD = 1'b0;
    repeat (8) @(posedge CLK);
    NRST <= 1'b1;
    t_reset();
    t_master();
    t_disable();
    t_busy_irq();
    t_slave(CON_SL, 1'b1, 8'h09, 8'hFE, 8'h08);
    t_slave(CON_FW, 1'b0, 8'h28, 8'h5A, 8'h00);
    summarize();
  end
endmodule : tb_top
